// File: beacon_mode_sequencer.sv
// Beacon mode sequencer and interleaved advertisement scheduler.
//
// Overview of operation
// [RL1] Up to ten slots merge into one schedule, each at its own interval.
// [RL2] Beaconing stays in inactivity sub-mode until an activity event arrives.
// [RL3] Activity event stops inactive-gated slots and starts active-gated slots.
// [RL4] Colliding due slots are resolved by priority, lowest index goes first.
// [RL5] Each losing slot of a collision is pushed back by at least 30 ms.
// [RL6] Active-gated slots send only after activity, until the activity timeout.
// [RL7] Always-enabled slots keep sending in the activity sub-mode.
// [RL8] Inactive-gated slots send only outside the activity sub-mode.
// [RL9] Always-enabled slots keep sending in the inactivity sub-mode.
// [RL10] Connections are accepted only while a connectable advertisement is being sent.
// [RL11] Every accelerometer interrupt source is masked while connected.
// [RL12] Configuration or activity timer keeps counting during a connection.
// [RL13] A timeout expiring while connected is applied at disconnection.
// [RL14] Without expiry the mode held at connection resumes on disconnection.
// [RL15] Configuration event moves beaconing or warehouse into configuration.
// [RL16] Flip source fires only on gravity going from minus Z to plus Z.
// [RL17] Configuration entry starts its timer; expiry goes to the startup check state.
// [RL18] On/off event: beaconing to warehouse, configuration or warehouse to beaconing.
// [RL19] Activity entry starts the activity timer; expiry returns to inactivity.
// [RL20] Timeout lengths and event sources are software settings.
// [RL21] Reset event clears slot memory and returns to the startup check state.
// [RL22] Every reset event is followed by a 500 ms connectable burst.
// [RL23] Every slot has its own gating setting and starts disabled.
// [RL24] A slot gated off is never scheduled.
`timescale 1ns/1ps
`default_nettype none
module beacon_mode_sequencer
    import beacon_pkg::*;
#(
    parameter int unsigned CYCLES_PER_MS = CYCLES_PER_MS_DEF
)
(
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    input  wire logic        ev_button,
    input  wire logic        ev_tap,
    input  wire logic        ev_dtap,
    input  wire logic        ev_motion,
    input  wire logic        grav_z_neg,
    input  wire logic        grav_z_pos,
    input  wire logic        conn_req,
    input  wire logic        conn_end,
    input  wire logic        link_reset_req,
    input  wire logic        test_en,
    output tx_s              tx,
    output logic             conn_accept,
    output logic             accel_irq_mask,
    output mode_e            mode,
    output logic             active,
    output logic             connected
);

    // --------------------
    // Helper functions
    // --------------------
    function automatic logic gate_ok(input logic [1:0] g, input logic act);
        logic ok;
        ok = 1'b0;
        unique case (gate_e'(g))
            GATE_OFF:      ok = 1'b0;            // [RL24]
            GATE_ALWAYS:   ok = 1'b1;            // [RL7] [RL9]
            GATE_ACTIVE:   ok = act;             // [RL6]
            GATE_INACTIVE: ok = !act;            // [RL8]
        endcase
        return ok;
    endfunction

    function automatic logic [4:0] slot_sel(input logic [7:0] a);
        logic [5:0] w;
        w = a[7:2] - REG_SLOT0[7:2];
        if (a >= REG_SLOT0 && w < 6'(NSLOT))
            return {1'b1, w[3:0]};
        return 5'h00;
    endfunction

    function automatic logic [31:0] load_val(input logic [31:0] t);
        return (t == 32'h0) ? 32'h1 : t;
    endfunction

    function automatic logic [IVL_W-1:0] reload(input logic [IVL_W-1:0] ivl);
        if (ivl < IVL_W'(SPACING_MS))
            return IVL_W'(SPACING_MS - 1);
        return ivl - IVL_W'(1);
    endfunction

    function automatic seq_state_s apply_timeout(input seq_state_s x);
        seq_state_s y;
        y = x;
        unique case (x.mode)
            MODE_CONFIG: // [RL17]
            begin
                y.mode = MODE_STARTUP;
                y.tmr  = 32'(BURST_MS); // [RL22]
            end
            MODE_BEACON:
            begin
                y.active = 1'b0; // [RL19]
                y.tmr    = 32'h0;
            end
            MODE_STARTUP:
            begin
                y.mode   = MODE_BEACON; // [RL2]
                y.active = 1'b0;
                y.tmr    = 32'h0;
            end
            MODE_WAREHOUSE:
            begin
                y.tmr = 32'h0;
            end
        endcase
        return y;
    endfunction

    // --------------------
    // Submodules
    // --------------------
    logic             tick;
    logic [NSLOT-1:0] due;
    logic [NSLOT-1:0] grant;
    logic [SLOT_W-1:0] grant_idx;

    ms_tick #(
        .CYCLES_PER_MS (CYCLES_PER_MS)
    ) u_tick (
        .mclk (mclk),
        .rstn (rstn),
        .tick (tick)
    );

    slot_arbiter u_arb (
        .req       (due),
        .grant     (grant),
        .grant_idx (grant_idx)
    );

    // --------------------
    // State
    // --------------------
    seq_state_s s_q;
    seq_state_s s_d;

    logic [NSLOT-1:0] elig;
    logic [3:0]       src_vec;
    logic             flip_evt;
    logic             cfg_evt;
    logic             onoff_evt;
    logic             act_evt;
    logic             rst_evt;
    logic             tmr_run;
    logic             tmr_done;
    logic             connectable_now;
    logic [4:0]       wsel;
    logic [4:0]       rsel;

    always_comb
    begin
        for (int i = 0; i < NSLOT; i++)
        begin
            elig[i] = (s_q.mode == MODE_BEACON) && !s_q.conn                // [RL1]
                && gate_ok(s_q.slot_cfg[i][SLOT_GATE_LSB +: 2], s_q.active); // [RL3]
            due[i]  = elig[i] && (s_q.slot_cnt[i] == '0);
        end
    end

    always_comb
    begin
        s_d = s_q;
        s_d.tx          = '0;
        s_d.conn_accept = 1'b0;
        s_d.rdata       = '0;

        // --------------------
        // Event sources
        // --------------------
        flip_evt = s_q.flip_armed && grav_z_pos && !s_q.conn; // [RL16]
        if (grav_z_neg)
            s_d.flip_armed = 1'b1; // [RL16]
        else if (grav_z_pos)
            s_d.flip_armed = 1'b0;
        src_vec   = {flip_evt, ev_dtap && !s_q.conn, ev_tap && !s_q.conn, ev_button};
        cfg_evt   = src_vec[s_q.ctrl[CTRL_CFG_LSB +: 2]]; // [RL20]
        onoff_evt = src_vec[s_q.ctrl[CTRL_ONOFF_LSB +: 2]]; // [RL20]
        act_evt   = ev_motion && !s_q.conn; // [RL11]
        s_d.test_en_prev = test_en;
        rst_evt = link_reset_req || (test_en != s_q.test_en_prev) // [RL21]
            || (wr && addr == REG_CMD && wdata[CMD_RESET_BIT]);

        // --------------------
        // Mode timer, counts in milliseconds
        // --------------------
        tmr_run  = (s_q.mode == MODE_STARTUP) || (s_q.mode == MODE_CONFIG)
            || (s_q.mode == MODE_BEACON && s_q.active);
        tmr_done = tmr_run && tick && (s_q.tmr == 32'h1);
        if (tmr_run && tick && s_q.tmr != 32'h0)
            s_d.tmr = s_q.tmr - 32'h1; // [RL12]

        connectable_now = (s_q.mode == MODE_STARTUP) || (s_q.mode == MODE_CONFIG);
        for (int i = 0; i < NSLOT; i++)
        begin
            if (elig[i] && s_q.slot_cfg[i][SLOT_CONN_BIT])
                connectable_now = 1'b1;
        end

        // --------------------
        // Register writes and reads
        // --------------------
        wsel = slot_sel(addr);
        rsel = wsel;
        if (wr)
        begin
            unique case (addr)
                REG_CTRL:   s_d.ctrl   = wdata; // [RL20]
                REG_CFG_TO: s_d.cfg_to = wdata; // [RL20]
                REG_ACT_TO: s_d.act_to = wdata; // [RL20]
                default:
                begin
                    if (wsel[4])
                        s_d.slot_cfg[wsel[3:0]] = wdata; // [RL23]
                end
            endcase
        end
        if (rd)
        begin
            unique case (addr)
                REG_CTRL:   s_d.rdata = s_q.ctrl;
                REG_CFG_TO: s_d.rdata = s_q.cfg_to;
                REG_ACT_TO: s_d.rdata = s_q.act_to;
                REG_STATUS: s_d.rdata = {27'h0, s_q.expire_pend, s_q.conn,
                                         s_q.active, s_q.mode};
                default:
                begin
                    if (rsel[4])
                        s_d.rdata = s_q.slot_cfg[rsel[3:0]];
                end
            endcase
        end

        // --------------------
        // Advertisement scheduler
        // --------------------
        if (tick)
        begin
            for (int i = 0; i < NSLOT; i++)
            begin
                if (!elig[i])
                    s_d.slot_cnt[i] = '0;
                else if (grant[i])
                    s_d.slot_cnt[i] = reload(s_q.slot_cfg[i][SLOT_IVL_LSB +: IVL_W]); // [RL1]
                else if (due[i])
                    s_d.slot_cnt[i] = IVL_W'(SPACING_MS - 1); // [RL5]
                else
                    s_d.slot_cnt[i] = s_q.slot_cnt[i] - IVL_W'(1);
            end
            if (|due)
            begin
                s_d.tx.valid       = 1'b1; // [RL4]
                s_d.tx.slot        = grant_idx;
                s_d.tx.connectable = s_q.slot_cfg[grant_idx][SLOT_CONN_BIT];
            end
        end

        if (connectable_now && s_q.mode != MODE_BEACON && !s_q.conn)
        begin
            if (tick)
            begin
                if (s_q.cadv_cnt == 5'h0)
                begin
                    s_d.tx.valid       = 1'b1; // [RL22]
                    s_d.tx.slot        = CONN_ADV_SLOT;
                    s_d.tx.connectable = 1'b1;
                    s_d.cadv_cnt       = 5'(SPACING_MS - 1);
                end
                else
                begin
                    s_d.cadv_cnt = s_q.cadv_cnt - 5'h1;
                end
            end
        end
        else
        begin
            s_d.cadv_cnt = 5'h0;
        end

        // --------------------
        // Mode transitions
        // --------------------
        if (rst_evt)
        begin
            s_d.mode        = MODE_STARTUP; // [RL21]
            s_d.active      = 1'b0;
            s_d.conn        = 1'b0;
            s_d.expire_pend = 1'b0;
            s_d.tmr         = 32'(BURST_MS); // [RL22]
            s_d.cadv_cnt    = 5'h0;
            s_d.tx          = '0;
            for (int i = 0; i < NSLOT; i++)
            begin
                s_d.slot_cfg[i] = SLOT_RST; // [RL21]
                s_d.slot_cnt[i] = '0;
            end
        end
        else if (s_q.conn)
        begin
            if (tmr_done)
                s_d.expire_pend = 1'b1; // [RL13]
            if (conn_end)
            begin
                s_d.conn        = 1'b0;
                s_d.expire_pend = 1'b0;
                if (s_q.expire_pend || tmr_done)
                    s_d = apply_timeout(s_d); // [RL13]
            end // [RL14]
        end
        else if (conn_req && connectable_now)
        begin
            s_d.conn        = 1'b1; // [RL10]
            s_d.conn_accept = 1'b1;
        end
        else
        begin
            unique case (s_q.mode)
                MODE_STARTUP:
                begin
                    if (tmr_done)
                        s_d = apply_timeout(s_d);
                end
                MODE_BEACON:
                begin
                    if (onoff_evt)
                    begin
                        s_d.mode   = MODE_WAREHOUSE; // [RL18]
                        s_d.active = 1'b0;
                        s_d.tmr    = 32'h0;
                    end
                    else if (cfg_evt)
                    begin
                        s_d.mode   = MODE_CONFIG; // [RL15]
                        s_d.active = 1'b0;
                        s_d.tmr    = load_val(s_q.cfg_to); // [RL17]
                    end
                    else if (act_evt && !s_q.active)
                    begin
                        s_d.active = 1'b1; // [RL2]
                        s_d.tmr    = load_val(s_q.act_to); // [RL19]
                    end
                    else if (tmr_done)
                    begin
                        s_d = apply_timeout(s_d); // [RL19]
                    end
                end
                MODE_CONFIG:
                begin
                    if (onoff_evt)
                    begin
                        s_d.mode   = MODE_BEACON; // [RL18]
                        s_d.active = 1'b0;
                        s_d.tmr    = 32'h0;
                    end
                    else if (tmr_done)
                    begin
                        s_d = apply_timeout(s_d); // [RL17]
                    end
                end
                MODE_WAREHOUSE:
                begin
                    if (onoff_evt)
                    begin
                        s_d.mode   = MODE_BEACON; // [RL18]
                        s_d.active = 1'b0;
                    end
                    else if (cfg_evt)
                    begin
                        s_d.mode = MODE_CONFIG; // [RL15]
                        s_d.tmr  = load_val(s_q.cfg_to); // [RL17]
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            s_q          <= '0;
            s_q.mode     <= MODE_STARTUP;
            s_q.tmr      <= 32'(BURST_MS);
            s_q.ctrl     <= CTRL_RST;
            s_q.cfg_to   <= CFG_TO_RST;
            s_q.act_to   <= ACT_TO_RST;
            s_q.slot_cfg <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // --------------------
    // Outputs
    // --------------------
    assign rdata          = s_q.rdata;
    assign tx             = s_q.tx;
    assign conn_accept    = s_q.conn_accept;
    assign accel_irq_mask = s_q.conn; // [RL11]
    assign mode           = s_q.mode;
    assign active         = s_q.active;
    assign connected      = s_q.conn;

endmodule
`default_nettype wire

// File: beacon_pkg.sv
// Shared constants, enumerations and carriers for the beacon mode sequencer.
`default_nettype none
package beacon_pkg;

    // --------------------
    // Sizes and timing
    // --------------------
    localparam int unsigned NSLOT             = 10;
    localparam int unsigned SLOT_W            = 4;
    localparam int unsigned IVL_W             = 26;
    localparam int unsigned CLK_HZ            = 125_000_000;
    localparam int unsigned MS_PER_S          = 1000;
    localparam int unsigned CYCLES_PER_MS_DEF = CLK_HZ / MS_PER_S;
    localparam int unsigned SPACING_MS        = 30;
    localparam int unsigned BURST_MS          = 500;

    // --------------------
    // Register offsets
    // --------------------
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_CFG_TO = 8'h04;
    localparam logic [7:0] REG_ACT_TO = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_CMD    = 8'h10;
    localparam logic [7:0] REG_SLOT0  = 8'h20;

    // --------------------
    // Field positions
    // --------------------
    localparam int unsigned CTRL_CFG_LSB   = 0;
    localparam int unsigned CTRL_ONOFF_LSB = 2;
    localparam int unsigned SLOT_GATE_LSB  = 0;
    localparam int unsigned SLOT_CONN_BIT  = 2;
    localparam int unsigned SLOT_IVL_LSB   = 6;
    localparam int unsigned CMD_RESET_BIT  = 0;

    // --------------------
    // Reset values and burst advert slot
    // --------------------
    localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
    localparam logic [31:0] CFG_TO_RST = 32'h0000_ea60;
    localparam logic [31:0] ACT_TO_RST = 32'h0000_2710;
    localparam logic [31:0] SLOT_RST   = 32'h0000_0000;
    localparam logic [3:0]  CONN_ADV_SLOT = 4'hf;

    // --------------------
    // Enumerations and carriers
    // --------------------
    typedef enum logic [1:0]
    {
        GATE_OFF      = 2'h0,
        GATE_ALWAYS   = 2'h1,
        GATE_ACTIVE   = 2'h2,
        GATE_INACTIVE = 2'h3
    } gate_e;

    typedef enum logic [1:0]
    {
        MODE_STARTUP   = 2'h0,
        MODE_BEACON    = 2'h1,
        MODE_CONFIG    = 2'h3,
        MODE_WAREHOUSE = 2'h2
    } mode_e;

    typedef struct packed
    {
        logic              valid;
        logic [SLOT_W-1:0] slot;
        logic              connectable;
    } tx_s;

    typedef struct packed
    {
        mode_e                         mode;
        logic                          active;
        logic                          conn;
        logic                          expire_pend;
        logic                          flip_armed;
        logic                          test_en_prev;
        logic                          conn_accept;
        logic [31:0]                   tmr;
        logic [4:0]                    cadv_cnt;
        logic [31:0]                   ctrl;
        logic [31:0]                   cfg_to;
        logic [31:0]                   act_to;
        logic [NSLOT-1:0][31:0]        slot_cfg;
        logic [NSLOT-1:0][IVL_W-1:0]   slot_cnt;
        logic [31:0]                   rdata;
        tx_s                           tx;
    } seq_state_s;

endpackage
`default_nettype wire

// File: ms_tick.sv
// Millisecond tick generator from the system clock.
`timescale 1ns/1ps
`default_nettype none
module ms_tick
    import beacon_pkg::*;
#(
    parameter int unsigned CYCLES_PER_MS = CYCLES_PER_MS_DEF
)
(
    input  wire logic mclk,
    input  wire logic rstn,
    output logic      tick
);

    localparam int unsigned CW = $clog2(CYCLES_PER_MS + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES_PER_MS - 1);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;

    // --------------------
    // Counter
    // --------------------
    always_comb
    begin
        cnt_d = (cnt_q == LAST) ? '0 : cnt_q + CW'(1);
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
            cnt_q <= '0;
        else
            cnt_q <= cnt_d;
    end

    assign tick = (cnt_q == LAST);

endmodule
`default_nettype wire

// File: slot_arbiter.sv
// Fixed priority pick among due advertisement slots, lowest index first.
`timescale 1ns/1ps
`default_nettype none
module slot_arbiter
    import beacon_pkg::*;
(
    input  wire logic [NSLOT-1:0]  req,
    output logic      [NSLOT-1:0]  grant,
    output logic      [SLOT_W-1:0] grant_idx
);

    // --------------------
    // Priority pick
    // --------------------
    always_comb
    begin
        grant     = '0;
        grant_idx = '0;
        for (int i = NSLOT - 1; i >= 0; i--)
        begin
            if (req[i])
            begin
                grant     = '0;
                grant[i]  = 1'b1;
                grant_idx = SLOT_W'(i);
            end
        end
    end

endmodule
`default_nettype wire

// File: beacon_mode_sequencer_props.sv
// Port checker for the beacon mode sequencer.
`timescale 1ns/1ps
`default_nettype none
module beacon_mode_sequencer_props
    import beacon_pkg::*;
#(parameter int unsigned CYCLES_PER_MS = CYCLES_PER_MS_DEF)
(
    input wire logic  mclk,
    input wire logic  rstn,
    input wire logic  conn_req,
    input wire logic  conn_end,
    input wire logic  link_reset_req,
    input wire tx_s   tx,
    input wire logic  conn_accept,
    input wire logic  accel_irq_mask,
    input wire mode_e mode,
    input wire logic  active,
    input wire logic  connected
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);
    sequence s_open;
        conn_accept && connected && accel_irq_mask;
    endsequence
    a_mask_conn: assert property (accel_irq_mask == connected)
        else $error("Mask differs from connection.");
    a_open_start: assert property (
        conn_req && !connected && mode == MODE_STARTUP |=> s_open)
        else $error("Connection refused in startup.");
    a_accept_cause: assert property (
        conn_accept |-> $past(conn_req) && !$past(connected))
        else $error("Accept without request.");
    a_tx_spacing: assert property (tx.valid |=> !tx.valid [*3])
        else $error("Adverts closer than one tick.");
    a_burst_conn: assert property (
        tx.valid && tx.slot == CONN_ADV_SLOT |-> tx.connectable)
        else $error("Burst advert not connectable.");
    a_store_quiet: assert property ($past(mode) == MODE_WAREHOUSE |-> !tx.valid)
        else $error("Advert sent in warehouse.");
    a_active_beacon: assert property (active |-> mode == MODE_BEACON)
        else $error("Activity outside beaconing.");
    a_reset_event: assert property (
        link_reset_req |=> mode == MODE_STARTUP && !connected && !active)
        else $error("Reset event missed.");
    a_end_drop: assert property (connected && conn_end |=> !connected)
        else $error("Connection kept after end.");
endmodule
bind beacon_mode_sequencer beacon_mode_sequencer_props
    #(.CYCLES_PER_MS(CYCLES_PER_MS)) chk_inst (.mclk(mclk), .rstn(rstn),
    .conn_req(conn_req), .conn_end(conn_end), .link_reset_req(link_reset_req), .tx(tx),
    .conn_accept(conn_accept), .accel_irq_mask(accel_irq_mask), .mode(mode),
    .active(active), .connected(connected));
`default_nettype wire

// File: scan_model.sv
// Scanner model that counts adverts per slot and opens links.
`timescale 1ns/1ps
`default_nettype none
module scan_model
    import beacon_pkg::*;
(
    input  wire logic mclk,
    input  wire tx_s  tx,
    output logic      conn_req,
    output logic      conn_end
);
    int   seen [16];
    logic clr = 1'b0;
    initial
    begin
        conn_req = 1'b0;
        conn_end = 1'b0;
    end
    always @(posedge mclk)
        if (clr)
            seen <= '{default: 0};
        else if (tx.valid === 1'b1)
            seen[tx.slot] <= seen[tx.slot] + 1;
    task automatic link(input logic up);
        if (up)
            wait (tx.valid === 1'b1 && tx.connectable === 1'b1);
        @(posedge mclk);
        if (up)
            conn_req <= 1'b1;
        else
            conn_end <= 1'b1;
        @(posedge mclk);
        conn_req <= 1'b0;
        conn_end <= 1'b0;
        @(posedge mclk);
    endtask
endmodule
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the beacon mode sequencer.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import beacon_pkg::*;
;
    logic        mclk = 1'b0;
    logic        rstn = 1'b0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [7:0]  evs = 8'h00;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic [31:0] rv;
    tx_s         tx;
    mode_e       mode;
    logic        conn_req, conn_end, conn_accept, accel_irq_mask, active, connected;
    int          fail_count = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    always #4 mclk = ~mclk;
    beacon_mode_sequencer #(.CYCLES_PER_MS(4)) beacon_mode_sequencer_inst (.mclk(mclk),
        .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .ev_button(evs[4]), .ev_tap(evs[0]), .ev_dtap(evs[1]), .ev_motion(evs[2]),
        .grav_z_neg(evs[5]), .grav_z_pos(evs[6]), .conn_req(conn_req), .conn_end(conn_end),
        .link_reset_req(evs[3]), .test_en(evs[7]), .tx(tx), .conn_accept(conn_accept),
        .accel_irq_mask(accel_irq_mask), .mode(mode), .active(active), .connected(connected));
    scan_model scan_model_inst (.mclk(mclk), .tx(tx), .conn_req(conn_req), .conn_end(conn_end));
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic ms(input int n);
        repeat (n * 4) @(posedge mclk);
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        @(posedge mclk);
        wr <= 1'b0;
        rd <= 1'b0;
        @(negedge mclk);
        rv = rdata;
    endtask
    task automatic pulse(input int i);
        @(posedge mclk);
        evs[i] <= 1'b1;
        @(posedge mclk);
        evs[i] <= 1'b0;
        ms(1);
    endtask
    task automatic t_startup;
        bus(1'b0, REG_ACT_TO, 32'h0);
        chk("act_to", rv, ACT_TO_RST);
        bus(1'b0, 8'h80, 32'h0);
        chk("unmapped", rv, 32'h0);
        ms(480);
        chk("mode_burst", mode, MODE_STARTUP);
        chk("burst_seen", scan_model_inst.seen[15] > 10, 1'b1);
        ms(40);
        chk("mode_after", mode, MODE_BEACON);
    endtask
    task automatic t_gating;
        bus(1'b1, REG_SLOT0, 32'h0000_1905);
        bus(1'b1, REG_SLOT0 + 8'h04, 32'h0000_1903);
        bus(1'b1, REG_SLOT0 + 8'h08, 32'h0000_0c82);
        bus(1'b1, REG_ACT_TO, 32'd200);
        scan_model_inst.clr = 1'b1;
        ms(300);
        scan_model_inst.clr = 1'b0;
        ms(300);
        chk("inact_act", scan_model_inst.seen[2], 0);
        chk("inact_inact", scan_model_inst.seen[1] != 0, 1'b1);
        chk("inact_always", scan_model_inst.seen[0] != 0, 1'b1);
        pulse(2);
        chk("active_on", active, 1'b1);
        scan_model_inst.clr = 1'b1;
        ms(1);
        scan_model_inst.clr = 1'b0;
        ms(150);
        chk("act_inact", scan_model_inst.seen[1], 0);
        chk("act_act", scan_model_inst.seen[2] != 0, 1'b1);
        chk("act_always", scan_model_inst.seen[0] != 0, 1'b1);
        chk("slot_off", scan_model_inst.seen[3], 0);
        ms(100);
        chk("active_off", active, 1'b0);
    endtask
    task automatic t_conn;
        pulse(2);
        scan_model_inst.link(1'b1);
        chk("connected", connected, 1'b1);
        chk("irq_mask", accel_irq_mask, 1'b1);
        ms(250);
        chk("act_held", active, 1'b1);
        scan_model_inst.link(1'b0);
        chk("act_deferred", active, 1'b0);
        pulse(2);
        scan_model_inst.link(1'b1);
        scan_model_inst.link(1'b0);
        chk("act_resume", active, 1'b1);
        chk("mode_resume", mode, MODE_BEACON);
    endtask
    task automatic t_modes;
        bus(1'b1, REG_CTRL, 32'h3);
        pulse(6);
        chk("flip_half", mode, MODE_BEACON);
        pulse(5);
        pulse(6);
        chk("flip_cfg", mode, MODE_CONFIG);
        pulse(4);
        chk("button_off", mode, MODE_BEACON);
        bus(1'b1, REG_CTRL, 32'h9);
        bus(1'b1, REG_CFG_TO, 32'd20);
        pulse(1);
        chk("to_store", mode, MODE_WAREHOUSE);
        pulse(0);
        chk("store_cfg", mode, MODE_CONFIG);
        pulse(1);
        chk("cfg_beacon", mode, MODE_BEACON);
        pulse(0);
        chk("beacon_cfg", mode, MODE_CONFIG);
        ms(25);
        chk("cfg_expiry", mode, MODE_STARTUP);
    endtask
    task automatic t_reset;
        pulse(3);
        chk("reset_mode", mode, MODE_STARTUP);
        bus(1'b0, REG_SLOT0, 32'h0);
        chk("slot_clear", rv, SLOT_RST);
        bus(1'b1, REG_SLOT0, 32'h0000_1905);
        pulse(7);
        bus(1'b0, REG_SLOT0, 32'h0);
        chk("test_en_clear", rv, SLOT_RST);
        scan_model_inst.link(1'b1);
        chk("burst_conn", connected, 1'b1);
        scan_model_inst.link(1'b0);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            finish_test();
        end
    end
    initial
    begin
        repeat (20) @(posedge mclk);
        rstn <= 1'b1;
        t_startup();
        t_gating();
        t_conn();
        t_modes();
        t_reset();
        finish_test();
    end
endmodule
`default_nettype wire
